// ### hdl/gpio_port_defs.svh
// offsets, field positions, reset values and counts of the four-bit port
`ifndef GPIO_PORT_DEFS_SVH
`define GPIO_PORT_DEFS_SVH

`define PORT_PIN_COUNT 4
`define PORT_ADDR_WIDTH 8
`define PORT_DATA_WIDTH 32

`define OFS_PIN_VALUE 8'h00
`define OFS_OUTPUT_DRIVER_ENABLE 8'h04
`define OFS_FUNCTION_SELECT_INTERRUPT 8'h0C
`define OFS_FUNCTION_SELECT_TIMER_CAPTURE 8'h10
`define OFS_PULLUP_ENABLE 8'h2C
`define OFS_INPUT_PATH_ENABLE 8'h38

`define FSI_WIDTH 2
`define FSI_INT_TWO_BIT 0
`define FSI_INT_THREE_BIT 1
`define FSC_TIMER_ONE_ZERO_BIT 0
`define FSC_TIMER_ONE_ONE_BIT 1
`define FSC_TIMER_SIX_ZERO_BIT 2
`define FSC_TIMER_SIX_ONE_BIT 3

`define RST_PIN_BITS 4'h0
`define RST_FSI_BITS 2'h0
`define RST_WORD 32'h00000000

`define BOOT_CNT_WIDTH 3
`define BOOT_SETTLE_CYCLES 3'h4

`endif

// ### hdl/gpio_port_pkg.sv
// types of the four-bit port: pad types, register select, state record
package gpio_port_pkg;

    typedef enum logic [2:0] {
        PAD_TYPE_FIRST = 3'b000,
        PAD_TYPE_SECOND = 3'b001,
        PAD_TYPE_THIRD = 3'b010,
        PAD_TYPE_FOURTH = 3'b011,
        PAD_TYPE_FIFTH = 3'b100,
        PAD_TYPE_SIXTH = 3'b101
    } pad_type_e;

    typedef enum logic [2:0] {
        SEL_NONE = 3'b000,
        SEL_PIN_VALUE = 3'b001,
        SEL_OUTPUT_DRIVER_ENABLE = 3'b010,
        SEL_FUNCTION_SELECT_INTERRUPT = 3'b011,
        SEL_FUNCTION_SELECT_TIMER_CAPTURE = 3'b100,
        SEL_PULLUP_ENABLE = 3'b101,
        SEL_INPUT_PATH_ENABLE = 3'b110
    } reg_sel_e;

    typedef enum logic {
        BOOT_WAIT = 1'b0,
        BOOT_DONE = 1'b1
    } boot_state_e;

    typedef struct packed {
        logic [3:0] pin_value_bits;
        logic [3:0] output_enable_bits;
        logic [1:0] interrupt_select_bits;
        logic [3:0] capture_select_bits;
        logic [3:0] pullup_bits;
        logic [3:0] input_enable_bits;
        logic [31:0] read_data;
        boot_state_e boot_state;
        logic [2:0] boot_cnt;
        logic [3:0] boot_level;
    } port_state_s;

endpackage : gpio_port_pkg

// ### hdl/pin_sync.sv
// three-stage synchroniser whose output moves once the last two stages agree
`timescale 1ns/100ps
module pin_sync #(
    parameter int WIDTH = 4
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // asynchronous levels in, filtered levels out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] level
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
        logic [WIDTH-1:0] stage3;
        logic [WIDTH-1:0] level;
    } sync_state_s;

    sync_state_s state_reg;
    sync_state_s state_next;

    always_comb
    begin
        state_next = state_reg;
        state_next.stage1 = async_in;
        state_next.stage2 = state_reg.stage1;
        state_next.stage3 = state_reg.stage2;
        // take the new level only where stages two and three agree
        state_next.level = (state_reg.stage2 & state_reg.stage3) |
            (state_reg.level & (state_reg.stage2 | state_reg.stage3));
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign level = state_reg.level;

endmodule : pin_sync

// ### hdl/pad_ctrl.sv
// per-pin pad control: drive, pull-up and input path by pad type
`timescale 1ns/100ps
module pad_ctrl #(
    parameter gpio_port_pkg::pad_type_e PAD_TYPE = gpio_port_pkg::PAD_TYPE_FIRST
) (
    // reset and boot window
    input wire logic sys_rst,
    input wire logic boot_window,
    // configuration of this pin
    input wire logic out_latch,
    input wire logic drive_en,
    input wire logic pup_en,
    input wire logic in_en,
    input wire logic func_sel,
    // peripheral function output
    input wire logic func_out,
    input wire logic func_out_en,
    // pad controls
    output logic pin_out,
    output logic pin_oe,
    output logic pullup_on,
    output logic input_open
);

    localparam bit FN_GATED = (PAD_TYPE == gpio_port_pkg::PAD_TYPE_SECOND) ||
        (PAD_TYPE == gpio_port_pkg::PAD_TYPE_THIRD);
    localparam bit PUP_KEPT = (PAD_TYPE == gpio_port_pkg::PAD_TYPE_SECOND) ||
        (PAD_TYPE == gpio_port_pkg::PAD_TYPE_SIXTH);
    localparam bit BOOT_PAD = (PAD_TYPE == gpio_port_pkg::PAD_TYPE_SIXTH);

    logic fn_drive;

    // gated pads drive a function output only on the peripheral's enable
    assign fn_drive = FN_GATED ? func_out_en : drive_en;
    assign pin_oe = sys_rst ? 1'b0 : (func_sel ? fn_drive : drive_en);
    assign pin_out = func_sel ? func_out : out_latch;
    assign pullup_on = PUP_KEPT ? pup_en : (pup_en & ~sys_rst);
    // output-only pad opens its input only for the boot strap
    assign input_open = BOOT_PAD ? boot_window : in_en;

endmodule : pad_ctrl

// ### hdl/gpio_port.sv
// four-bit port with register file, function routing and boot strap catch
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/100ps
`include "gpio_port_defs.svh"
module gpio_port #(
    parameter gpio_port_pkg::pad_type_e PAD_TYPE [`PORT_PIN_COUNT] =
        '{default: gpio_port_pkg::PAD_TYPE_FIRST}
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // register port
    input wire logic [`PORT_ADDR_WIDTH-1:0] reg_addr,
    input wire logic [`PORT_DATA_WIDTH-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`PORT_DATA_WIDTH-1:0] reg_rdata,
    // pads
    input wire logic [`PORT_PIN_COUNT-1:0] pin_in,
    output logic [`PORT_PIN_COUNT-1:0] pin_out,
    output logic [`PORT_PIN_COUNT-1:0] pin_oe,
    output logic [`PORT_PIN_COUNT-1:0] pullup_on,
    output logic [`PORT_PIN_COUNT-1:0] input_buf_en,
    // peripheral function outputs toward the pads
    input wire logic [`PORT_PIN_COUNT-1:0] func_out,
    input wire logic [`PORT_PIN_COUNT-1:0] func_out_en,
    // power mode
    input wire logic deepest_stop_mode,
    // alternate function inputs toward interrupt and timers
    output logic external_interrupt_two,
    output logic external_interrupt_three,
    output logic timer_one_capture_zero,
    output logic timer_one_capture_one,
    output logic timer_six_capture_zero,
    output logic timer_six_capture_one,
    // boot strap
    output logic [`PORT_PIN_COUNT-1:0] boot_level,
    output logic boot_level_valid
);

    gpio_port_pkg::port_state_s state_reg;
    gpio_port_pkg::port_state_s state_next;
    gpio_port_pkg::reg_sel_e sel;
    logic [`PORT_PIN_COUNT-1:0] pin_level;
    logic [`PORT_PIN_COUNT-1:0] path_open;
    logic [`PORT_PIN_COUNT-1:0] func_sel;
    logic [`PORT_PIN_COUNT-1:0] fsi_wide;
    logic [`PORT_PIN_COUNT-1:0] readback;
    logic [`PORT_PIN_COUNT-1:0] boot_mask;
    logic boot_window;
    logic int_two_route;
    logic int_three_route;

    function automatic gpio_port_pkg::reg_sel_e decode(
        input logic [`PORT_ADDR_WIDTH-1:0] addr
    );
        unique case (addr)
            `OFS_PIN_VALUE: decode = gpio_port_pkg::SEL_PIN_VALUE;
            `OFS_OUTPUT_DRIVER_ENABLE: decode = gpio_port_pkg::SEL_OUTPUT_DRIVER_ENABLE;
            `OFS_FUNCTION_SELECT_INTERRUPT: decode = gpio_port_pkg::SEL_FUNCTION_SELECT_INTERRUPT;
            `OFS_FUNCTION_SELECT_TIMER_CAPTURE:
                decode = gpio_port_pkg::SEL_FUNCTION_SELECT_TIMER_CAPTURE;
            `OFS_PULLUP_ENABLE: decode = gpio_port_pkg::SEL_PULLUP_ENABLE;
            `OFS_INPUT_PATH_ENABLE: decode = gpio_port_pkg::SEL_INPUT_PATH_ENABLE;
            default: decode = gpio_port_pkg::SEL_NONE;
        endcase
    endfunction : decode

    function automatic logic [`PORT_DATA_WIDTH-1:0] pad_word(
        input logic [`PORT_PIN_COUNT-1:0] bits
    );
        pad_word = {{(`PORT_DATA_WIDTH-`PORT_PIN_COUNT){1'b0}}, bits};
    endfunction : pad_word

    pin_sync #(
        .WIDTH(`PORT_PIN_COUNT)
    ) u_pin_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .async_in(pin_in),
        .level(pin_level)
    );

    assign boot_window = sys_rst | (state_reg.boot_state == gpio_port_pkg::BOOT_WAIT);
    assign fsi_wide = {2'h0, state_reg.interrupt_select_bits};
    assign func_sel = fsi_wide | state_reg.capture_select_bits;

    genvar gi;
    generate
        for (gi = 0; gi < `PORT_PIN_COUNT; gi++)
        begin : g_pad
            pad_ctrl #(
                .PAD_TYPE(PAD_TYPE[gi])
            ) u_pad_ctrl (
                .sys_rst(sys_rst),
                .boot_window(boot_window),
                .out_latch(state_reg.pin_value_bits[gi]),
                .drive_en(state_reg.output_enable_bits[gi]),
                .pup_en(state_reg.pullup_bits[gi]),
                .in_en(state_reg.input_enable_bits[gi]),
                .func_sel(func_sel[gi]),
                .func_out(func_out[gi]),
                .func_out_en(func_out_en[gi]),
                .pin_out(pin_out[gi]),
                .pin_oe(pin_oe[gi]),
                .pullup_on(pullup_on[gi]),
                .input_open(path_open[gi])
            );
            assign boot_mask[gi] = (PAD_TYPE[gi] == gpio_port_pkg::PAD_TYPE_SIXTH);
        end
    endgenerate

    assign input_buf_en = path_open;

    // driven pins read the latch, open inputs the sampled level
    assign readback = (state_reg.output_enable_bits & state_reg.pin_value_bits) |
        (~state_reg.output_enable_bits & path_open & pin_level);

    // in deepest stop only a selected pin still reaches its interrupt
    assign int_two_route = ~deepest_stop_mode |
        state_reg.interrupt_select_bits[`FSI_INT_TWO_BIT];
    assign int_three_route = ~deepest_stop_mode |
        state_reg.interrupt_select_bits[`FSI_INT_THREE_BIT];
    assign external_interrupt_two = pin_level[0] & path_open[0] & int_two_route;
    assign external_interrupt_three = pin_level[1] & path_open[1] & int_three_route;

    assign timer_one_capture_zero = pin_level[0] & path_open[0] &
        state_reg.capture_select_bits[`FSC_TIMER_ONE_ZERO_BIT];
    assign timer_one_capture_one = pin_level[1] & path_open[1] &
        state_reg.capture_select_bits[`FSC_TIMER_ONE_ONE_BIT];
    assign timer_six_capture_zero = pin_level[2] & path_open[2] &
        state_reg.capture_select_bits[`FSC_TIMER_SIX_ZERO_BIT];
    assign timer_six_capture_one = pin_level[3] & path_open[3] &
        state_reg.capture_select_bits[`FSC_TIMER_SIX_ONE_BIT];

    always_comb
    begin
        state_next = state_reg;
        sel = decode(reg_addr);
        if (reg_wr)
        begin
            unique case (sel)
                gpio_port_pkg::SEL_PIN_VALUE:
                    state_next.pin_value_bits = reg_wdata[`PORT_PIN_COUNT-1:0];
                gpio_port_pkg::SEL_OUTPUT_DRIVER_ENABLE:
                    state_next.output_enable_bits = reg_wdata[`PORT_PIN_COUNT-1:0];
                gpio_port_pkg::SEL_FUNCTION_SELECT_INTERRUPT:
                    state_next.interrupt_select_bits = reg_wdata[`FSI_WIDTH-1:0];
                gpio_port_pkg::SEL_FUNCTION_SELECT_TIMER_CAPTURE:
                    state_next.capture_select_bits = reg_wdata[`PORT_PIN_COUNT-1:0];
                gpio_port_pkg::SEL_PULLUP_ENABLE:
                    state_next.pullup_bits = reg_wdata[`PORT_PIN_COUNT-1:0];
                gpio_port_pkg::SEL_INPUT_PATH_ENABLE:
                    state_next.input_enable_bits = reg_wdata[`PORT_PIN_COUNT-1:0];
                gpio_port_pkg::SEL_NONE:
                begin
                end
            endcase
        end
        // read data stand for one cycle only; unmapped reads give zero
        state_next.read_data = `RST_WORD;
        if (reg_rd)
        begin
            unique case (sel)
                gpio_port_pkg::SEL_PIN_VALUE:
                    state_next.read_data = pad_word(readback);
                gpio_port_pkg::SEL_OUTPUT_DRIVER_ENABLE:
                    state_next.read_data = pad_word(state_reg.output_enable_bits);
                gpio_port_pkg::SEL_FUNCTION_SELECT_INTERRUPT:
                    state_next.read_data = pad_word(fsi_wide);
                gpio_port_pkg::SEL_FUNCTION_SELECT_TIMER_CAPTURE:
                    state_next.read_data = pad_word(state_reg.capture_select_bits);
                gpio_port_pkg::SEL_PULLUP_ENABLE:
                    state_next.read_data = pad_word(state_reg.pullup_bits);
                gpio_port_pkg::SEL_INPUT_PATH_ENABLE:
                    state_next.read_data = pad_word(state_reg.input_enable_bits);
                gpio_port_pkg::SEL_NONE:
                    state_next.read_data = `RST_WORD;
            endcase
        end
        // catch the boot level once the synchroniser has settled after release
        unique case (state_reg.boot_state)
            gpio_port_pkg::BOOT_WAIT:
            begin
                if (state_reg.boot_cnt == `BOOT_SETTLE_CYCLES)
                begin
                    state_next.boot_level = pin_level & boot_mask;
                    state_next.boot_state = gpio_port_pkg::BOOT_DONE;
                end
                else
                begin
                    state_next.boot_cnt = state_reg.boot_cnt + 3'h1;
                end
            end
            gpio_port_pkg::BOOT_DONE:
            begin
            end
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_reg.pin_value_bits <= `RST_PIN_BITS;
            state_reg.output_enable_bits <= `RST_PIN_BITS;
            state_reg.interrupt_select_bits <= `RST_FSI_BITS;
            state_reg.capture_select_bits <= `RST_PIN_BITS;
            state_reg.pullup_bits <= `RST_PIN_BITS;
            state_reg.input_enable_bits <= `RST_PIN_BITS;
            state_reg.read_data <= `RST_WORD;
            state_reg.boot_state <= gpio_port_pkg::BOOT_WAIT;
            state_reg.boot_cnt <= 3'h0;
            state_reg.boot_level <= `RST_PIN_BITS;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign reg_rdata = state_reg.read_data;
    assign boot_level = state_reg.boot_level;
    assign boot_level_valid = (state_reg.boot_state == gpio_port_pkg::BOOT_DONE);

endmodule : gpio_port

// ### sim/gpio_port_asserts.sv
// checker of read-out, pad control and boot capture of the four-bit port
`timescale 1ns/100ps
`include "gpio_port_defs.svh"
module gpio_port_asserts (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // register port
    input wire logic [`PORT_ADDR_WIDTH-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [`PORT_DATA_WIDTH-1:0] reg_rdata,
    // pads and functions
    input wire logic [`PORT_PIN_COUNT-1:0] pin_oe,
    input wire logic [`PORT_PIN_COUNT-1:0] pullup_on,
    input wire logic [`PORT_PIN_COUNT-1:0] input_buf_en,
    input wire logic external_interrupt_two,
    input wire logic timer_one_capture_zero,
    input wire logic boot_level_valid
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
        else $error("read data not zero outside read slot");
    chk_upper_zero: assert property ($past(reg_rd) |-> reg_rdata[31:4] == '0)
        else $error("upper read bits not zero");
    chk_select_upper: assert property ($past(reg_rd) &&
        $past(reg_addr) == `OFS_FUNCTION_SELECT_INTERRUPT |-> reg_rdata[31:2] == '0)
        else $error("interrupt select upper bits not zero");
    chk_reset_clear: assert property ($fell(sys_rst) |->
        pin_oe == '0 && pullup_on == '0 && input_buf_en[2:0] == '0)
        else $error("pad controls not cleared by reset");
    chk_int_gate: assert property (external_interrupt_two |-> input_buf_en[0])
        else $error("interrupt seen with input path blocked");
    chk_cap_gate: assert property (timer_one_capture_zero |-> input_buf_en[0])
        else $error("capture seen with input path blocked");
    chk_oe_write: assert property ($changed(pin_oe[0]) |-> $past(reg_wr))
        else $error("driver enable moved without a write");
    chk_pup_write: assert property ($changed(pullup_on[0]) |-> $past(reg_wr))
        else $error("pull-up moved without a write");
    chk_boot_done: assert property ($fell(sys_rst) |->
        !boot_level_valid ##[1:6] boot_level_valid)
        else $error("boot level not captured in time");
endmodule : gpio_port_asserts

bind gpio_port gpio_port_asserts i_gpio_port_asserts (.mclk(mclk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pin_oe(pin_oe), .pullup_on(pullup_on), .input_buf_en(input_buf_en),
    .external_interrupt_two(external_interrupt_two),
    .timer_one_capture_zero(timer_one_capture_zero), .boot_level_valid(boot_level_valid));

// ### sim/board_model.sv
// board circuitry on the four pads: external drivers, pull-ups, floating lines
`timescale 1ns/100ps
`include "gpio_port_defs.svh"
module board_model (
    // clock
    input wire logic mclk,
    // pad side of the port
    input wire logic [`PORT_PIN_COUNT-1:0] pin_out,
    input wire logic [`PORT_PIN_COUNT-1:0] pin_oe,
    input wire logic [`PORT_PIN_COUNT-1:0] pullup_on,
    output logic [`PORT_PIN_COUNT-1:0] pin_in,
    // external drivers set by the bench
    input wire logic [`PORT_PIN_COUNT-1:0] ext_val,
    input wire logic [`PORT_PIN_COUNT-1:0] ext_en
);
    logic [`PORT_PIN_COUNT-1:0] float_lvl = 4'h0;
    // an undriven line toggles so it never passes for a steady level
    always @(posedge mclk)
        float_lvl <= ~float_lvl;
    always_comb
        for (int i = 0; i < `PORT_PIN_COUNT; i++)
            pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
                pullup_on[i] ? 1'b1 : float_lvl[i];
endmodule : board_model

// ### sim/tb.sv
// bench of the four-bit port: registers, pads, functions and boot capture
`timescale 1ns/100ps
`include "gpio_port_defs.svh"
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin miscompares++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h00000000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [3:0] pin_in, pin_out, pin_oe, pullup_on, input_buf_en, boot_level;
    logic [3:0] func_out = 4'h0;
    logic [3:0] func_out_en = 4'h0;
    logic [3:0] ext_val = 4'h0;
    logic [3:0] ext_en = 4'h8;
    logic deepest_stop_mode = 1'b0;
    logic int_two, int_three, t1c0, t1c1, t6c0, t6c1, boot_level_valid;
    int miscompares = 0;
    int cmp_count = 0;
    logic [7:0] addrs [6] = '{`OFS_PIN_VALUE, `OFS_OUTPUT_DRIVER_ENABLE,
        `OFS_FUNCTION_SELECT_INTERRUPT, `OFS_FUNCTION_SELECT_TIMER_CAPTURE,
        `OFS_PULLUP_ENABLE, `OFS_INPUT_PATH_ENABLE};
    logic [31:0] masks [6] = '{32'h0000000F, 32'h0000000F, 32'h00000003, 32'h0000000F,
        32'h0000000F, 32'h0000000F};

    gpio_port #(.PAD_TYPE('{gpio_port_pkg::PAD_TYPE_FIRST, gpio_port_pkg::PAD_TYPE_SECOND,
        gpio_port_pkg::PAD_TYPE_THIRD, gpio_port_pkg::PAD_TYPE_SIXTH})) i_gpio_port (
        .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on),
        .input_buf_en(input_buf_en), .func_out(func_out), .func_out_en(func_out_en),
        .deepest_stop_mode(deepest_stop_mode), .external_interrupt_two(int_two),
        .external_interrupt_three(int_three), .timer_one_capture_zero(t1c0),
        .timer_one_capture_one(t1c1), .timer_six_capture_zero(t6c0),
        .timer_six_capture_one(t6c1), .boot_level(boot_level),
        .boot_level_valid(boot_level_valid));
    board_model i_board_model (.mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pullup_on(pullup_on), .pin_in(pin_in), .ext_val(ext_val), .ext_en(ext_en));

    always #12.5 mclk = ~mclk;

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : final_report

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ex);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        `CHK("read data", ex, reg_rdata)
    endtask : rd

    // reset, boot strap capture and register defaults
    task automatic do_reset(input logic [3:0] boot_ex);
        int n;
        @(posedge mclk);
        sys_rst <= 1'b1;
        cyc(9);
        `CHK("boot input open", 1'b1, input_buf_en[3])
        `CHK("drivers in reset", 4'h0, pin_oe)
        `CHK("pull-ups in reset", 4'h0, pullup_on & 4'h5)
        @(posedge mclk);
        sys_rst <= 1'b0;
        n = 0;
        while (boot_level_valid !== 1'b1 && n < 20)
        begin
            cyc(1);
            n++;
        end
        if (n == 20)
        begin
            miscompares++;
            final_report();
        end
        `CHK("boot level", boot_ex, boot_level)
        `CHK("boot input closed", 1'b0, input_buf_en[3])
        for (int i = 0; i < 6; i++)
            rd(addrs[i], 32'h00000000);
    endtask : do_reset

    initial
    begin
        do_reset(4'h0);
        for (int i = 1; i < 6; i++)
        begin
            wr(addrs[i], 32'hFFFFFFFF);
            rd(addrs[i], masks[i]);
            wr(addrs[i], 32'h00000000);
        end
        wr(8'h08, 32'hFFFFFFFF);
        rd(8'h08, 32'h00000000);
        // output port
        wr(`OFS_OUTPUT_DRIVER_ENABLE, 32'h0000000F);
        wr(`OFS_PIN_VALUE, 32'hFFFFFFFA);
        rd(`OFS_PIN_VALUE, 32'h0000000A);
        `CHK("drive enables", 2'b11, {pin_oe[3], pin_oe[0]})
        `CHK("pad levels", 2'b10, {pin_out[3], pin_out[0]})
        // input port and interrupts
        wr(`OFS_OUTPUT_DRIVER_ENABLE, 32'h00000000);
        wr(`OFS_INPUT_PATH_ENABLE, 32'h00000007);
        ext_en <= 4'hF;
        ext_val <= 4'hB;
        cyc(6);
        rd(`OFS_PIN_VALUE, 32'h00000003);
        `CHK("int two free", 1'b1, int_two)
        `CHK("int three free", 1'b1, int_three)
        @(posedge mclk);
        deepest_stop_mode <= 1'b1;
        cyc(1);
        `CHK("int pair in stop", 2'b00, {int_three, int_two})
        wr(`OFS_FUNCTION_SELECT_INTERRUPT, 32'h00000001);
        `CHK("int pair sel0", 2'b01, {int_three, int_two})
        wr(`OFS_FUNCTION_SELECT_INTERRUPT, 32'h00000002);
        `CHK("int pair sel1", 2'b10, {int_three, int_two})
        wr(`OFS_FUNCTION_SELECT_INTERRUPT, 32'h00000000);
        @(posedge mclk);
        deepest_stop_mode <= 1'b0;
        // timer captures
        wr(`OFS_FUNCTION_SELECT_TIMER_CAPTURE, 32'h0000000F);
        `CHK("captures high", 4'h3, {t6c1, t6c0, t1c1, t1c0})
        ext_val <= 4'h4;
        cyc(6);
        `CHK("captures low", 4'h4, {t6c1, t6c0, t1c1, t1c0})
        wr(`OFS_INPUT_PATH_ENABLE, 32'h00000000);
        rd(`OFS_PIN_VALUE, 32'h00000000);
        `CHK("captures blocked", 4'h0, {t6c1, t6c0, t1c1, t1c0})
        // gated function output
        wr(`OFS_FUNCTION_SELECT_TIMER_CAPTURE, 32'h00000002);
        wr(`OFS_OUTPUT_DRIVER_ENABLE, 32'h00000002);
        ext_en <= 4'h8;
        @(posedge mclk);
        func_out <= 4'h2;
        cyc(1);
        `CHK("gated drive off", 1'b0, pin_oe[1])
        @(posedge mclk);
        func_out_en <= 4'h2;
        cyc(1);
        `CHK("gated drive on", 2'b11, {pin_oe[1], pin_out[1]})
        // pull-ups, analog use, then reset in mid-run with a high strap
        wr(`OFS_PULLUP_ENABLE, 32'h0000000F);
        `CHK("pull-ups on", 4'hF, pullup_on)
        wr(`OFS_PULLUP_ENABLE, 32'h00000000);
        `CHK("analog pad quiet", 2'b00, {pullup_on[2], input_buf_en[2]})
        wr(`OFS_PULLUP_ENABLE, 32'h0000000F);
        ext_val <= 4'h8;
        do_reset(4'h8);
        final_report();
    end
endmodule : tb
